/* File: hw/lbsd_pkg.sv */
`default_nettype none
package lbsd_pkg;
   localparam int unsigned LAMP_COUNT = 5;
   // a high stage extinguishes its lamp, low lights it
   localparam logic LAMP_OFF = 1'h1;
   localparam logic LAMP_ON = 1'h0;
   localparam logic [4:0] LAMPS_ALL_ON = 5'h00;
   localparam logic [4:0] LAMPS_RESET = 5'h1F;
   localparam logic [2:0] SYNC_RESET = 3'h7;

   typedef struct packed {
      logic clear_n;
      logic shift_clock;
      logic serial_data;
   } lbsd_lines_type;
endpackage
`default_nettype wire

/* File: hw/lbsd_top.sv */
`default_nettype none
// Function
// - while the clear line is low all five lamp outputs are forced low.
// - each rising edge of the shift clock while the clear line is high captures the data line into lamp one.
// - a captured low lights its lamp and a high extinguishes it.
// - each capture edge moves every lamp state one stage toward lamp five.
module lbsd_top #(
   parameter int unsigned LAMPS = lbsd_pkg::LAMP_COUNT
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic BAR_CLEAR_LINE_N,
   input wire logic BAR_SHIFT_CLOCK,
   input wire logic BAR_SERIAL_DATA,
   output logic [LAMPS-1:0] BAR_LAMPS
);
   // the three host lines are asynchronous to CLK; each gets two stages
   lbsd_pkg::lbsd_lines_type raw_lines;
   lbsd_pkg::lbsd_lines_type sync1_q;
   lbsd_pkg::lbsd_lines_type sync2_q;
   logic clk_prev_q;
   logic [LAMPS-1:0] lamps_q;
   logic [LAMPS-1:0] lamps_d;
   wire logic [LAMPS-1:0] stage_src;
   // check-only bookkeeping: captures seen since the last clear
   localparam int unsigned FILL_W = $clog2(LAMPS + 1);
   localparam logic [FILL_W-1:0] FILL_ONE = FILL_W'(1);
   localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(LAMPS);
   logic [FILL_W-1:0] fill_q;
   logic seen_clear_q;
   wire logic capture_edge;
   wire logic clear_active;

   // one driver for the whole struct; field order is clear, clock, data
   assign raw_lines = {BAR_CLEAR_LINE_N, BAR_SHIFT_CLOCK, BAR_SERIAL_DATA};

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         sync1_q <= lbsd_pkg::SYNC_RESET;
         sync2_q <= lbsd_pkg::SYNC_RESET;
      end
      else
      begin
         sync1_q <= raw_lines;
         sync2_q <= sync1_q;
      end
   end

   // clock idles high, so reset to high avoids a false edge at release
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         clk_prev_q <= 1'h1;
      else
         clk_prev_q <= sync2_q.shift_clock;
   end

   // data is synchronised with the clock, keeping their relative timing
   assign capture_edge = sync2_q.shift_clock & ~clk_prev_q;
   assign clear_active = ~sync2_q.clear_n;

   // stage zero takes the data bit, every later stage its predecessor
   assign stage_src[0] = sync2_q.serial_data;
   for (genvar s = 1; s < LAMPS; s++)
   begin : g_stage
      assign stage_src[s] = lamps_q[s-1];

      a_stage_moves: assert property (
         @(posedge CLK) disable iff (!NRST)
         (capture_edge && !clear_active)
            |=> (lamps_q[s] == $past(lamps_q[s-1])))
         else $error("stage did not take its predecessor");

      a_stage_cleared: assert property (
         @(posedge CLK) disable iff (!NRST)
         clear_active |=> (lamps_q[s] == lbsd_pkg::LAMP_ON))
         else $error("stage not lit under clear");

      a_stage_still_lit: assert property (
         @(posedge CLK) disable iff (!NRST)
         (seen_clear_q && fill_q <= s) |-> (lamps_q[s] == lbsd_pkg::LAMP_ON))
         else $error("lamp lost its clear state early");
   end

   // clear outranks a coincident edge; lamps all turn on while it holds
   assign lamps_d = clear_active ? {LAMPS{lbsd_pkg::LAMP_ON}}
      : capture_edge ? stage_src
      : lamps_q;

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         lamps_q <= {LAMPS{lbsd_pkg::LAMP_OFF}};
      else
         lamps_q <= lamps_d;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         fill_q <= '0;
         seen_clear_q <= 1'h0;
      end
      else if (clear_active)
      begin
         fill_q <= '0;
         seen_clear_q <= 1'h1;
      end
      else if (capture_edge && fill_q != FILL_FULL)
         fill_q <= fill_q + FILL_ONE;
   end

   assign BAR_LAMPS = lamps_q;

   a_clear_forces_on: assert property (
      @(posedge CLK) disable iff (!NRST)
      clear_active |=> (lamps_q == {LAMPS{lbsd_pkg::LAMP_ON}}))
      else $error("lamps not all on after clear");

   a_capture_data: assert property (
      @(posedge CLK) disable iff (!NRST)
      (capture_edge && !clear_active)
         |=> (lamps_q[0] == $past(sync2_q.serial_data)))
      else $error("lamp one did not take data");

   a_shift_onward: assert property (
      @(posedge CLK) disable iff (!NRST)
      (capture_edge && !clear_active)
         |=> (lamps_q[LAMPS-1:1] == $past(lamps_q[LAMPS-2:0])))
      else $error("lamps did not shift");

   a_hold_no_edge: assert property (
      @(posedge CLK) disable iff (!NRST)
      (!capture_edge && !clear_active) |=> $stable(lamps_q))
      else $error("lamps changed without edge");

   // a pin edge has to pass both sync stages before it is acted on
   sequence s_pin_rise;
      !BAR_SHIFT_CLOCK ##1 BAR_SHIFT_CLOCK;
   endsequence

   sequence s_pin_rise_kept;
      s_pin_rise ##0 BAR_CLEAR_LINE_N;
   endsequence

   a_edge_detect: assert property (
      @(posedge CLK) disable iff (!NRST)
      s_pin_rise |-> ##2 capture_edge)
      else $error("rising edge missed");

   a_low_lights: assert property (
      @(posedge CLK) disable iff (!NRST)
      (capture_edge && !clear_active && !sync2_q.serial_data)
         |=> (lamps_q[0] == lbsd_pkg::LAMP_ON))
      else $error("low data did not light lamp");

   a_output_follows: assert property (
      @(posedge CLK) disable iff (!NRST)
      clear_active [*2] |-> (BAR_LAMPS == lbsd_pkg::LAMPS_ALL_ON))
      else $error("output not all on under clear");

   a_no_edge_high: assert property (
      @(posedge CLK) disable iff (!NRST)
      BAR_SHIFT_CLOCK [*4] |-> !capture_edge)
      else $error("edge on steady high clock");

   a_pin_to_lamp: assert property (
      @(posedge CLK) disable iff (!NRST)
      s_pin_rise_kept |-> ##3 (BAR_LAMPS[0] == $past(BAR_SERIAL_DATA, 3)))
      else $error("lamp one does not match data pin");

   a_pin_low_lights: assert property (
      @(posedge CLK) disable iff (!NRST)
      (s_pin_rise_kept ##0 !BAR_SERIAL_DATA)
         |-> ##3 (BAR_LAMPS[0] == lbsd_pkg::LAMP_ON))
      else $error("low data pin did not light lamp one");

   a_pin_high_dark: assert property (
      @(posedge CLK) disable iff (!NRST)
      (s_pin_rise_kept ##0 BAR_SERIAL_DATA)
         |-> ##3 (BAR_LAMPS[0] == lbsd_pkg::LAMP_OFF))
      else $error("high data pin did not darken lamp one");

   a_pin_shift: assert property (
      @(posedge CLK) disable iff (!NRST)
      s_pin_rise_kept
         |-> ##3 (BAR_LAMPS[LAMPS-1:1] == $past(BAR_LAMPS[LAMPS-2:0])))
      else $error("lamps did not move one stage");

   a_pin_clear: assert property (
      @(posedge CLK) disable iff (!NRST)
      !BAR_CLEAR_LINE_N |-> ##3 (BAR_LAMPS == {LAMPS{lbsd_pkg::LAMP_ON}}))
      else $error("clear pin did not light every lamp");

   a_clear_wins_edge: assert property (
      @(posedge CLK) disable iff (!NRST)
      (capture_edge && clear_active)
         |=> (lamps_q == {LAMPS{lbsd_pkg::LAMP_ON}}))
      else $error("edge overrode clear");

   a_high_darkens: assert property (
      @(posedge CLK) disable iff (!NRST)
      (capture_edge && !clear_active && sync2_q.serial_data)
         |=> (lamps_q[0] == lbsd_pkg::LAMP_OFF))
      else $error("high data did not darken lamp");

   a_clear_keeps: assert property (
      @(posedge CLK) disable iff (!NRST)
      clear_active [*3] |-> $stable(lamps_q))
      else $error("lamps moved while clear held");

   a_release_lit: assert property (
      @(posedge CLK) disable iff (!NRST)
      $rose(sync2_q.clear_n) |-> (lamps_q == {LAMPS{lbsd_pkg::LAMP_ON}}))
      else $error("lamps not all on at clear release");

   a_change_cause: assert property (
      @(posedge CLK) disable iff (!NRST)
      !$stable(lamps_q) |-> $past(capture_edge || clear_active))
      else $error("lamps changed with no capture or clear");
endmodule
`default_nettype wire

/* File: verification/lbsd_host.sv */
`default_nettype none
module lbsd_host (
   output var lbsd_pkg::lbsd_lines_type LINES,
   input wire logic CLK
);
   timeunit 1ns;
   timeprecision 1ps;
   initial LINES = 3'h7;
   task automatic shift_bit(input logic b);
      repeat (4) @(negedge CLK);
      LINES.serial_data = b;
      LINES.shift_clock = 1'h0;
      repeat (4) @(negedge CLK);
      LINES.shift_clock = 1'h1;
      repeat (4) @(negedge CLK);
      // stale data must not look valid after the hold
      LINES.serial_data = ~b;
   endtask
   task automatic set_clear(input logic c);
      LINES.clear_n = c;
   endtask
endmodule
`default_nettype wire

/* File: verification/led_bar_shift_driver_tb_top.sv */
`default_nettype none
module led_bar_shift_driver_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
$display("[FAIL] %0t lamps %h exp %h", $time, a, e); end end
   logic clk = 1'h0;
   logic nrst = 1'h0;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   logic [4:0] exp;
   logic [4:0] lamps;
   lbsd_pkg::lbsd_lines_type lines;
   // shifted bits, bit 0 first, beside the final lamps
   logic [4:0] rows [4][2] = '{'{5'h14, 5'h05}, '{5'h1F, 5'h1F},
      '{5'h00, 5'h00}, '{5'h01, 5'h10}};
   lbsd_host host (.LINES(lines), .CLK(clk));
   lbsd_top DUT (.CLK(clk), .NRST(nrst), .BAR_CLEAR_LINE_N(lines.clear_n),
      .BAR_SHIFT_CLOCK(lines.shift_clock),
      .BAR_SERIAL_DATA(lines.serial_data), .BAR_LAMPS(lamps));
   task automatic wrap_up();
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic shift_chk(input logic b);
      host.shift_bit(b);
      exp = {exp[3:0], b};
      `CHK(lamps, exp)
   endtask
   initial forever #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         fails++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (8) @(negedge clk);
      nrst = 1'h1;
      exp = lbsd_pkg::LAMPS_RESET;
      foreach (rows[i])
      begin
         for (int k = 0; k < 5; k++)
            shift_chk(rows[i][0][k]);
         `CHK(lamps, rows[i][1])
      end
      host.set_clear(1'h0);
      repeat (4) @(negedge clk);
      `CHK(lamps, 5'h00)
      host.shift_bit(1'h1);
      `CHK(lamps, 5'h00)
      host.set_clear(1'h1);
      exp = 5'h00;
      shift_chk(1'h1);
      nrst = 1'h0;
      @(negedge clk);
      nrst = 1'h1;
      exp = lbsd_pkg::LAMPS_RESET;
      shift_chk(1'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
